// ---- common/isi_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef ISI_REGS_SVH
`define ISI_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define ISI_OFS_CTRL 8'h00
`define ISI_OFS_STAT 8'h04
`define ISI_OFS_INT_STAT 8'h08
`define ISI_OFS_INT_MASK 8'h0c
`define ISI_OFS_CH_EN 8'h10
`define ISI_OFS_CH_LAMP 8'h14
`define ISI_OFS_CH_FLT 8'h18

// ==========================================================
// field positions
`define ISI_CTRL_VAR_LSB 0
`define ISI_CTRL_TEST_BIT 2
`define ISI_EV_MOD_FAULT 0
`define ISI_EV_COMM_LOST 1
`define ISI_EV_CH_FAULT 2
`define ISI_EV_CH_FIELD 3
`define ISI_EV_SYNC_LOST 4
`define ISI_EV_W 5

// ==========================================================
// reset values
`define ISI_CTRL_RST 3'h0
`define ISI_MASK_RST 5'h00
`define ISI_CH_EN_RST 16'hffff

// ==========================================================
// timing
`define ISI_CLK_PERIOD_NS 10
`define ISI_FLASH_HALF_MS 250
`define ISI_FLASH_HALF_CYC \
  (`ISI_FLASH_HALF_MS * (1000000 / `ISI_CLK_PERIOD_NS))

`endif

// ---- common/isi_pkg.sv ----
// types shared by the status indicator block
package isi_pkg;

  // ========================================================
  // lamp colour codes
  typedef enum logic [1:0] {
    ISI_OFF = 2'h0,
    ISI_GREEN = 2'h1,
    ISI_RED = 2'h2,
    ISI_YELLOW = 2'h3
  } isi_color_t;

  // ========================================================
  // module variant
  typedef enum logic [1:0] {
    ISI_VAR_DIN = 2'h0,
    ISI_VAR_DOUT = 2'h1,
    ISI_VAR_AIN = 2'h3
  } isi_var_t;

  // ========================================================
  // module-level conditions
  typedef struct packed {
    logic cfg_done;
    logic mod_fault;
    logic partner_sync;
    logic bp_comm;
    logic conn_est;
  } isi_mod_t;

  // ========================================================
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } isi_bus_t;

endpackage

// ---- rtl/isi_top.sv ----
// status indicator driver for redundant digital and analog i/o modules
//
// Notes on behaviour
// - health lamp steady green when configured and no module fault
// - health lamp flashes green until configuration is received
// - health lamp steady red on any module-level fault
// - redundancy lamp steady green while synchronized with partner
// - redundancy lamp dark when no partner present
// - run lamp steady green with at least one connection
// - run lamp flashes green with backplane but no connection
// - run lamp dark without backplane communication
// - digital input channel lamp dark when off or backplane lost
// - digital channel lamp steady yellow when on or energized
// - digital output channel lamp dark when off or de-energized
// - channel lamp flashes yellow on a field-side fault
// - channel lamp steady red on an internal channel fault
// - analog channel lamp steady yellow when valid signal present
// - analog channel lamp dark without signal or backplane
`timescale 1ns/1ps
`include "isi_regs.svh"

module isi_top #(
  parameter int NCH = 16,
  parameter int FLASH_HALF_CYC = `ISI_FLASH_HALF_CYC
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  // register port
  input wire isi_pkg::isi_bus_t BUS_I,
  output logic [31:0] RDATA_O,
  // module conditions
  input wire isi_pkg::isi_mod_t MOD_I,
  // channel conditions
  input wire logic [NCH-1:0] CH_ON_I,
  input wire logic [NCH-1:0] CH_FIELD_I,
  input wire logic [NCH-1:0] CH_FAULT_I,
  // lamps
  output logic [1:0] HEALTH_O,
  output logic [1:0] REDUND_O,
  output logic [1:0] RUN_O,
  output logic [2*NCH-1:0] CHAN_O,
  // interrupt
  output logic IRQ_O
);

  // ========================================================
  // local widths
  localparam int CW = (FLASH_HALF_CYC > 1) ? $clog2(FLASH_HALF_CYC) : 1;
  localparam int EW = `ISI_EV_W;

  // ========================================================
  // state
  logic [CW-1:0] flash_cnt_q;
  logic [CW-1:0] flash_cnt_d;
  logic flash_q;
  logic flash_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [EW-1:0] int_stat_q;
  logic [EW-1:0] int_stat_d;
  logic [EW-1:0] int_mask_q;
  logic [EW-1:0] int_mask_d;
  logic [NCH-1:0] ch_en_q;
  logic [NCH-1:0] ch_en_d;
  logic mod_fault_prev_q;
  logic bp_prev_q;
  logic sync_prev_q;
  logic ch_fault_prev_q;
  logic ch_field_prev_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] health_q;
  logic [1:0] health_d;
  logic [1:0] redund_q;
  logic [1:0] redund_d;
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [2*NCH-1:0] chan_q;
  logic [2*NCH-1:0] chan_d;
  logic irq_q;
  logic irq_d;

  // ========================================================
  // register decode
  wire logic wr_ctrl = BUS_I.wr && (BUS_I.addr == `ISI_OFS_CTRL);
  wire logic wr_stat = BUS_I.wr && (BUS_I.addr == `ISI_OFS_INT_STAT);
  wire logic wr_mask = BUS_I.wr && (BUS_I.addr == `ISI_OFS_INT_MASK);
  wire logic wr_chen = BUS_I.wr && (BUS_I.addr == `ISI_OFS_CH_EN);
  wire logic rd_ctrl = BUS_I.rd && (BUS_I.addr == `ISI_OFS_CTRL);
  wire logic rd_sts = BUS_I.rd && (BUS_I.addr == `ISI_OFS_STAT);
  wire logic rd_int = BUS_I.rd && (BUS_I.addr == `ISI_OFS_INT_STAT);
  wire logic rd_mask = BUS_I.rd && (BUS_I.addr == `ISI_OFS_INT_MASK);
  wire logic rd_chen = BUS_I.rd && (BUS_I.addr == `ISI_OFS_CH_EN);
  wire logic rd_lamp = BUS_I.rd && (BUS_I.addr == `ISI_OFS_CH_LAMP);
  wire logic rd_flt = BUS_I.rd && (BUS_I.addr == `ISI_OFS_CH_FLT);

  // ========================================================
  // control fields
  wire isi_pkg::isi_var_t variant =
    isi_pkg::isi_var_t'(ctrl_q[`ISI_CTRL_VAR_LSB +: 2]);
  wire logic lamp_test = ctrl_q[`ISI_CTRL_TEST_BIT];
  wire logic is_dout = (variant == isi_pkg::ISI_VAR_DOUT);

  // ========================================================
  // shared flash phase
  wire logic flash_wrap = (flash_cnt_q == CW'(FLASH_HALF_CYC - 1));
  assign flash_cnt_d = flash_wrap ? '0 : flash_cnt_q + CW'(1);
  assign flash_d = flash_wrap ? ~flash_q : flash_q;

  wire isi_pkg::isi_color_t green_fl =
    flash_q ? isi_pkg::ISI_GREEN : isi_pkg::ISI_OFF;
  wire isi_pkg::isi_color_t yellow_fl =
    flash_q ? isi_pkg::ISI_YELLOW : isi_pkg::ISI_OFF;

  // ========================================================
  // health lamp
  wire isi_pkg::isi_color_t health_col =
    MOD_I.mod_fault ? isi_pkg::ISI_RED :
    !MOD_I.cfg_done ? green_fl :
    isi_pkg::ISI_GREEN;

  // ========================================================
  // redundancy lamp
  wire isi_pkg::isi_color_t redund_col =
    MOD_I.partner_sync ? isi_pkg::ISI_GREEN :
    isi_pkg::ISI_OFF;

  // ========================================================
  // run lamp
  wire isi_pkg::isi_color_t run_col =
    !MOD_I.bp_comm ? isi_pkg::ISI_OFF :
    MOD_I.conn_est ? isi_pkg::ISI_GREEN :
    green_fl;

  // ========================================================
  // channel lamps
  wire logic bp_dark = !is_dout && !MOD_I.bp_comm;
  logic [2*NCH-1:0] chan_col;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      wire isi_pkg::isi_color_t lit =
        CH_FAULT_I[gi] ? isi_pkg::ISI_RED :
        CH_FIELD_I[gi] ? yellow_fl :
        CH_ON_I[gi] ? isi_pkg::ISI_YELLOW :
        isi_pkg::ISI_OFF;
      assign chan_col[2*gi +: 2] =
        (bp_dark || !ch_en_q[gi]) ? isi_pkg::ISI_OFF : lit;
    end
  endgenerate

  // ========================================================
  // lamp selection, test overrides all lamps
  assign health_d = lamp_test ? isi_pkg::ISI_YELLOW : health_col;
  assign redund_d = lamp_test ? isi_pkg::ISI_YELLOW : redund_col;
  assign run_d = lamp_test ? isi_pkg::ISI_YELLOW : run_col;
  assign chan_d = lamp_test ? {NCH{isi_pkg::ISI_YELLOW}} : chan_col;

  // ========================================================
  // events
  wire logic any_fault = |(CH_FAULT_I & ch_en_q);
  wire logic any_field = |(CH_FIELD_I & ch_en_q);
  logic [EW-1:0] ev;
  assign ev[`ISI_EV_MOD_FAULT] = MOD_I.mod_fault && !mod_fault_prev_q;
  assign ev[`ISI_EV_COMM_LOST] = !MOD_I.bp_comm && bp_prev_q;
  assign ev[`ISI_EV_CH_FAULT] = any_fault && !ch_fault_prev_q;
  assign ev[`ISI_EV_CH_FIELD] = any_field && !ch_field_prev_q;
  assign ev[`ISI_EV_SYNC_LOST] = !MOD_I.partner_sync && sync_prev_q;

  // ========================================================
  // register updates, set wins over write-one-clear
  wire logic [EW-1:0] clr = wr_stat ? BUS_I.wdata[EW-1:0] : '0;
  assign int_stat_d = (int_stat_q & ~clr) | ev;
  assign int_mask_d = wr_mask ? BUS_I.wdata[EW-1:0] : int_mask_q;
  assign ctrl_d = wr_ctrl ? BUS_I.wdata[2:0] : ctrl_q;
  assign ch_en_d = wr_chen ? BUS_I.wdata[NCH-1:0] : ch_en_q;
  assign irq_d = |(int_stat_d & int_mask_d);

  // ========================================================
  // read data, valid only in the cycle after the strobe
  wire logic [31:0] sts_word = {
    20'h00000, flash_q, run_q, redund_q, health_q,
    MOD_I.cfg_done, MOD_I.mod_fault, MOD_I.partner_sync,
    MOD_I.bp_comm, MOD_I.conn_est
  };
  wire logic [31:0] flt_word = {
    (16)'(CH_FAULT_I), (16)'(CH_FIELD_I)
  };
  assign rdata_d =
    rd_ctrl ? {29'h0, ctrl_q} :
    rd_sts ? sts_word :
    rd_int ? {{(32-EW){1'b0}}, int_stat_q} :
    rd_mask ? {{(32-EW){1'b0}}, int_mask_q} :
    rd_chen ? 32'(ch_en_q) :
    rd_lamp ? 32'(chan_q) :
    rd_flt ? flt_word :
    32'h0;

  // ========================================================
  // flash timer counter
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flash_cnt_q <= '0;
    end else begin
      flash_cnt_q <= flash_cnt_d;
    end
  end

  // ========================================================
  // flash phase
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flash_q <= 1'b0;
    end else begin
      flash_q <= flash_d;
    end
  end

  // ========================================================
  // control register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_q <= `ISI_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ========================================================
  // interrupt status register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  // ========================================================
  // interrupt mask register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      int_mask_q <= `ISI_MASK_RST;
    end else begin
      int_mask_q <= int_mask_d;
    end
  end

  // ========================================================
  // channel enable register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ch_en_q <= NCH'(`ISI_CH_EN_RST);
    end else begin
      ch_en_q <= ch_en_d;
    end
  end

  // ========================================================
  // read data register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ========================================================
  // module fault history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mod_fault_prev_q <= 1'b0;
    end else begin
      mod_fault_prev_q <= MOD_I.mod_fault;
    end
  end

  // ========================================================
  // backplane history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bp_prev_q <= 1'b0;
    end else begin
      bp_prev_q <= MOD_I.bp_comm;
    end
  end

  // ========================================================
  // partner sync history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= MOD_I.partner_sync;
    end
  end

  // ========================================================
  // channel fault history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ch_fault_prev_q <= 1'b0;
    end else begin
      ch_fault_prev_q <= any_fault;
    end
  end

  // ========================================================
  // field fault history
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ch_field_prev_q <= 1'b0;
    end else begin
      ch_field_prev_q <= any_field;
    end
  end

  // ========================================================
  // health lamp output
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      health_q <= isi_pkg::ISI_OFF;
    end else begin
      health_q <= health_d;
    end
  end

  // ========================================================
  // redundancy lamp output
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      redund_q <= isi_pkg::ISI_OFF;
    end else begin
      redund_q <= redund_d;
    end
  end

  // ========================================================
  // run lamp output
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run_q <= isi_pkg::ISI_OFF;
    end else begin
      run_q <= run_d;
    end
  end

  // ========================================================
  // channel lamp outputs
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      chan_q <= '0;
    end else begin
      chan_q <= chan_d;
    end
  end

  // ========================================================
  // interrupt output
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign HEALTH_O = health_q;
  assign REDUND_O = redund_q;
  assign RUN_O = run_q;
  assign CHAN_O = chan_q;
  assign IRQ_O = irq_q;
  assign RDATA_O = rdata_q;

endmodule

// ---- test/isi_top_properties.sv ----
// concurrent checks on the status indicator ports
`timescale 1ns/1ps
module isi_chk #(
  parameter int NCH = 16
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  // register port
  input wire isi_pkg::isi_bus_t BUS_I,
  input wire logic [31:0] RDATA_O,
  // conditions
  input wire isi_pkg::isi_mod_t MOD_I,
  input wire logic [NCH-1:0] CH_ON_I,
  input wire logic [NCH-1:0] CH_FIELD_I,
  input wire logic [NCH-1:0] CH_FAULT_I,
  // lamps and interrupt
  input wire logic [1:0] HEALTH_O,
  input wire logic [1:0] REDUND_O,
  input wire logic [1:0] RUN_O,
  input wire logic [2*NCH-1:0] CHAN_O,
  input wire logic IRQ_O
);
  // ==========================================================
  // lamp and read port checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  health_red_a: assert property (
    MOD_I.mod_fault |=> HEALTH_O == 2'h2) else $error("health not red");
  health_green_a: assert property (
    MOD_I.cfg_done && !MOD_I.mod_fault |=> HEALTH_O == 2'h1)
    else $error("health not green");
  redund_on_a: assert property (
    MOD_I.partner_sync |=> REDUND_O == 2'h1) else $error("redund off");
  redund_off_a: assert property (
    !MOD_I.partner_sync |=> REDUND_O == 2'h0) else $error("redund lit");
  run_off_a: assert property (
    !MOD_I.bp_comm |=> RUN_O == 2'h0) else $error("run lit");
  run_green_a: assert property (
    MOD_I.bp_comm && MOD_I.conn_est |=> RUN_O == 2'h1)
    else $error("run not green");
  flash_phase_a: assert property (
    !MOD_I.cfg_done && !MOD_I.mod_fault && MOD_I.bp_comm && !MOD_I.conn_est
    |=> HEALTH_O == RUN_O) else $error("flash phases differ");
  chan_on_a: assert property (
    CH_ON_I[0] && !CH_FIELD_I[0] && !CH_FAULT_I[0] && MOD_I.bp_comm
    |=> CHAN_O[1:0] == 2'h3) else $error("channel 0 not yellow");
  chan_fault_a: assert property (
    CH_FAULT_I[2] && MOD_I.bp_comm |=> CHAN_O[5:4] == 2'h2)
    else $error("channel 2 not red");
  rdata_idle_a: assert property (
    !$past(BUS_I.rd) |-> RDATA_O == 32'h0) else $error("read data stray");
endmodule
bind isi_top isi_chk #(.NCH(NCH)) chk_u (.REF_CLK_I(REF_CLK_I),
  .RST_B_I(RST_B_I), .BUS_I(BUS_I), .RDATA_O(RDATA_O), .MOD_I(MOD_I),
  .CH_ON_I(CH_ON_I), .CH_FIELD_I(CH_FIELD_I), .CH_FAULT_I(CH_FAULT_I),
  .HEALTH_O(HEALTH_O), .REDUND_O(REDUND_O), .RUN_O(RUN_O),
  .CHAN_O(CHAN_O), .IRQ_O(IRQ_O));

// ---- test/isi_tb_top.sv ----
// self-checking bench for the status indicator block
`timescale 1ns/1ps
`include "isi_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module io_module_status_indicator_logic_tb_top;
  localparam int NCH = 4;
  localparam int FH = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  isi_pkg::isi_bus_t bus = '0;
  isi_pkg::isi_mod_t mods = '0;
  logic [NCH-1:0] on = '0;
  logic [NCH-1:0] fld = '0;
  logic [NCH-1:0] flt = '0;
  logic [31:0] rdata;
  logic [1:0] health;
  logic [1:0] redund;
  logic [1:0] run;
  logic [2*NCH-1:0] chan;
  logic irq;
  logic [31:0] d;
  logic [13:0] a;
  logic [13:0] o;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ==========================================================
  // design and clock
  isi_top #(.NCH(NCH), .FLASH_HALF_CYC(FH)) dut_u (.REF_CLK_I(clk),
    .RST_B_I(rst_b), .BUS_I(bus), .RDATA_O(rdata), .MOD_I(mods),
    .CH_ON_I(on), .CH_FIELD_I(fld), .CH_FAULT_I(flt),
    .HEALTH_O(health), .REDUND_O(redund), .RUN_O(run), .CHAN_O(chan),
    .IRQ_O(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // bus cycles and lamp sampling
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    bus <= '{ad, wd, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    bus <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // and and or of all lamps over one flash period plus two cycles
  task automatic watch();
    a = '1;
    o = '0;
    repeat (2 * FH + 2) begin
      @(posedge clk);
      #1;
      a &= {health, redund, run, chan};
      o |= {health, redund, run, chan};
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic reg_reset();
    rd(`ISI_OFS_CTRL);
    `CHK(d, 32'h0)
    rd(`ISI_OFS_INT_MASK);
    `CHK(d, 32'h0)
    rd(`ISI_OFS_CH_EN);
    `CHK(d, 32'hf)
    rd(8'h1c);
    `CHK(d, 32'h0)
  endtask
  task automatic mod_case(input logic [4:0] m, input logic [5:0] eo,
      input logic [5:0] ea);
    @(posedge clk);
    mods <= m;
    watch();
    `CHK(o[13:8], eo)
    `CHK(a[13:8], ea)
  endtask
  task automatic chan_case(input logic [1:0] v, input logic bp,
      input logic [7:0] eo, input logic [7:0] ea);
    wr(`ISI_OFS_CTRL, {30'h0, v});
    @(posedge clk);
    mods <= {3'b100, bp, 1'b1};
    on <= 4'h7;
    fld <= 4'h6;
    flt <= 4'h4;
    watch();
    `CHK(o[7:0], eo)
    `CHK(a[7:0], ea)
  endtask
  task automatic irq_case();
    @(posedge clk);
    mods <= 5'b10111;
    wr(`ISI_OFS_INT_STAT, 32'h1f);
    wr(`ISI_OFS_INT_MASK, 32'h1);
    @(posedge clk);
    mods <= 5'b11011;
    @(posedge clk);
    #1 `CHK(irq, 1'b1)
    rd(`ISI_OFS_INT_STAT);
    `CHK(d, 32'h11)
    wr(`ISI_OFS_INT_STAT, 32'h1);
    rd(`ISI_OFS_INT_STAT);
    `CHK({irq, d}, 33'h10)
    wr(`ISI_OFS_INT_MASK, 32'h10);
    rd(`ISI_OFS_INT_STAT);
    `CHK({irq, d}, 33'h1_0000_0010)
  endtask
  task automatic reg_view();
    rd(`ISI_OFS_STAT);
    `CHK(d[10:0], 11'h25b)
    rd(`ISI_OFS_CH_FLT);
    `CHK(d, 32'h0004_0006)
    rd(`ISI_OFS_CH_LAMP);
    `CHK(d[7:0] & 8'hf3, 8'h23)
  endtask
  // ==========================================================
  // run control
  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reg_reset();
    mod_case(5'b11000, 6'h20, 6'h20);
    mod_case(5'b01010, 6'h21, 6'h20);
    mod_case(5'b00111, 6'h15, 6'h05);
    mod_case(5'b10010, 6'h11, 6'h10);
    mod_case(5'b00010, 6'h11, 6'h00);
    chan_case(isi_pkg::ISI_VAR_DIN, 1'b1, 8'h2f, 8'h23);
    chan_case(isi_pkg::ISI_VAR_DIN, 1'b0, 8'h00, 8'h00);
    chan_case(isi_pkg::ISI_VAR_DOUT, 1'b0, 8'h2f, 8'h23);
    chan_case(isi_pkg::ISI_VAR_AIN, 1'b1, 8'h2f, 8'h23);
    chan_case(isi_pkg::ISI_VAR_AIN, 1'b0, 8'h00, 8'h00);
    wr(`ISI_OFS_CH_EN, 32'hd);
    chan_case(isi_pkg::ISI_VAR_DIN, 1'b1, 8'h23, 8'h23);
    wr(`ISI_OFS_CH_EN, 32'hf);
    irq_case();
    reg_view();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
